//--- core/ict_map.svh
// Register map, field positions and reset values of the interval counter channel
// Function
// - Mode 0: control word drives output low; it rises when count reaches zero
// - Mode 0: gate high counts, gate low holds; gate never touches output
// - Mode 0: count loads on next falling edge undecremented; output rises after N+1
// - Mode 0 two-byte: first byte suspends counting, output low at once
// - Mode 0: count written with gate low still loads; N pulses after gate rises
// - Mode 1: output high, low after trigger for N clocks, then high again
// - Mode 1: gate fall ignored; gate rise retriggers and reloads holding register
// - Mode 1: new count leaves running pulse alone until next retrigger
// - Mode 2: output low for one clock when count reaches 1, then reload
// - Mode 2: gate low stops and forces output high; gate rise reloads
// - Mode 2: initial count loads next falling edge; output low N clocks later
// - Mode 2: new count loads on trigger, otherwise at end of cycle
// - Mode 3: square wave of period N, high first half, low second
// - Mode 3 even: load N, step by two, toggle and reload at 2
// - Mode 3 odd: load N-1, low at zero, high at 2, high (N+1)/2
// - Mode 3: gate low stops and forces output high; trigger reloads
// - Mode 3: new count loads on trigger, otherwise at half cycle end
// - Mode 4: output high, low one clock when count reaches zero
// - Mode 4: gate high counts, gate low holds; gate never touches output
// - Mode 4: count loads next falling edge undecremented; strobe after N+1
// - Mode 4 two-byte: first byte harmless; second byte reloads, strobe N+1 later
// - Count zero means 65536 binary or 10000 BCD in every mode
// - Modes 1 to 3: gate rising edge is the trigger, retrigger in mode 1
`ifndef ICT_MAP_SVH
`define ICT_MAP_SVH
`define ICT_OFS_CTRL 8'h00
`define ICT_OFS_COUNT 8'h04
`define ICT_OFS_STATUS 8'h08
`define ICT_OFS_ELEMENT 8'h0C
`define ICT_CW_BCD 0
`define ICT_CW_MODE_LO 1
`define ICT_CW_MODE_HI 3
`define ICT_CW_RL_LO 4
`define ICT_CW_RL_HI 5
`define ICT_ST_OUT 7
`define ICT_ST_NULL 6
`define ICT_RL_LATCH 2'h0
`define ICT_RL_LSB 2'h1
`define ICT_RL_MSB 2'h2
`define ICT_RL_BOTH 2'h3
`define ICT_CW_RESET 6'h00
`define ICT_OUT_RESET 1'b0
`define ICT_COUNT_RESET 16'h0000
`define ICT_SQ_TERM 16'h0002
`define ICT_RATE_TERM 16'h0001
`endif

//--- core/ict_pkg.sv
// Types shared by the interval counter channel
package ict_pkg;
  typedef enum logic [2:0] {
    MODE_TERM,
    MODE_ONESHOT,
    MODE_RATE,
    MODE_SQUARE,
    MODE_STROBE,
    MODE_NONE
  } mode_type;
endpackage : ict_pkg

//--- core/ict_sync2.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module ict_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      meta_r <= '0;
      dout <= '0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule : ict_sync2

//--- core/ict_counter.sv
// One interval counter channel, modes 0 to 4, with an APB register slave
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "ict_map.svh"
module ict_counter (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CNT_CLK,
  input wire logic GATE,
  output logic OUT
);
  import ict_pkg::*;

  logic [1:0] pins_s;
  logic clk_s;
  logic gate_s;
  logic clk_d_r;
  logic gate_d_r;
  logic tick;
  logic gate_rise;
  logic setup;
  logic wr;
  logic ctrl_wr;
  logic data_wr;
  logic first_byte;
  logic count_done;
  logic [15:0] count_val;
  logic [5:0] cw_r;
  mode_type mode_r;
  mode_type new_mode;
  logic lsb_wait_r;
  logic [7:0] count_holding_low_byte_r;
  logic [15:0] count_holding_register_r;
  logic [15:0] count_element_r;
  logic [15:0] dec_one;
  logic [15:0] dec_two;
  logic [15:0] sq_reload;
  logic sq_term;
  logic out_r;
  logic run_r;
  logic load_pend_r;
  logic have_count_r;
  logic null_r;
  logic trig_pend_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;

  // One step down, binary or four BCD digits, wrapping at zero
  function automatic logic [15:0] dec_step(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - 16'h0001;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (borrow) begin
          if (v[i*4 +: 4] == 4'h0) begin
            r[i*4 +: 4] = 4'h9;
          end else begin
            r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction : dec_step

  function automatic mode_type decode_mode(input logic [2:0] m);
    mode_type r;
    r = MODE_NONE;
    if (m == 3'h0) begin
      r = MODE_TERM;
    end else if (m == 3'h1) begin
      r = MODE_ONESHOT;
    end else if (m[1:0] == 2'h2) begin
      r = MODE_RATE;
    end else if (m[1:0] == 2'h3) begin
      r = MODE_SQUARE;
    end else if (m == 3'h4) begin
      r = MODE_STROBE;
    end
    return r;
  endfunction : decode_mode

  // Counter clock and gate are asynchronous pins
  ict_sync2 #(.WIDTH(2)) u_sync (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .din({GATE, CNT_CLK}),
    .dout(pins_s)
  );
  assign clk_s = pins_s[0];
  assign gate_s = pins_s[1];

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      clk_d_r <= 1'b0;
      gate_d_r <= 1'b0;
    end else begin
      clk_d_r <= clk_s;
      gate_d_r <= gate_s;
    end
  end

  assign tick = clk_d_r & ~clk_s;
  assign gate_rise = gate_s & ~gate_d_r;

  // APB decode; writes land on the access edge only
  assign setup = PSEL & ~PENABLE;
  assign wr = PSEL & PENABLE & pready_r & PWRITE;
  assign ctrl_wr = wr && (PADDR == `ICT_OFS_CTRL);
  assign data_wr = wr && (PADDR == `ICT_OFS_COUNT);
  assign new_mode = decode_mode(PWDATA[`ICT_CW_MODE_HI:`ICT_CW_MODE_LO]);

  always_comb begin
    first_byte = 1'b0;
    count_done = 1'b0;
    count_val = count_holding_register_r;
    if (data_wr) begin
      if (cw_r[`ICT_CW_RL_HI:`ICT_CW_RL_LO] == `ICT_RL_LSB) begin
        count_done = 1'b1;
        count_val = {8'h00, PWDATA[7:0]};
      end else if (cw_r[`ICT_CW_RL_HI:`ICT_CW_RL_LO] == `ICT_RL_MSB) begin
        count_done = 1'b1;
        count_val = {PWDATA[7:0], 8'h00};
      end else if (cw_r[`ICT_CW_RL_HI:`ICT_CW_RL_LO] == `ICT_RL_BOTH) begin
        first_byte = ~lsb_wait_r;
        count_done = lsb_wait_r;
        count_val = {PWDATA[7:0], count_holding_low_byte_r};
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cw_r <= `ICT_CW_RESET;
      mode_r <= MODE_NONE;
      lsb_wait_r <= 1'b0;
      count_holding_low_byte_r <= 8'h00;
      count_holding_register_r <= `ICT_COUNT_RESET;
    end else begin
      if (ctrl_wr) begin
        cw_r <= PWDATA[5:0];
        mode_r <= new_mode;
        lsb_wait_r <= 1'b0;
      end else begin
        if (first_byte) begin
          count_holding_low_byte_r <= PWDATA[7:0];
          lsb_wait_r <= 1'b1;
        end
        if (count_done) begin
          count_holding_register_r <= count_val;
          lsb_wait_r <= 1'b0;
        end
      end
    end
  end

  // Trigger held until the next falling counter clock; set wins over clear
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      trig_pend_r <= 1'b0;
    end else if (gate_rise) begin
      trig_pend_r <= 1'b1;
    end else if (tick || ctrl_wr) begin
      trig_pend_r <= 1'b0;
    end
  end

  assign dec_one = dec_step(count_element_r, cw_r[`ICT_CW_BCD]);
  assign dec_two = dec_step(dec_one, cw_r[`ICT_CW_BCD]);
  // Odd counts drop the low bit; zero stays 65536, or 10000 in BCD
  assign sq_reload = {count_holding_register_r[15:1], 1'b0};
  assign sq_term = (count_holding_register_r[0] && out_r) ? (count_element_r == 16'h0000) :
                   (count_element_r == `ICT_SQ_TERM);

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      count_element_r <= `ICT_COUNT_RESET;
      out_r <= `ICT_OUT_RESET;
      run_r <= 1'b0;
      load_pend_r <= 1'b0;
      have_count_r <= 1'b0;
      null_r <= 1'b0;
    end else if (ctrl_wr) begin
      count_element_r <= `ICT_COUNT_RESET;
      out_r <= (new_mode != MODE_TERM);
      run_r <= 1'b0;
      load_pend_r <= 1'b0;
      have_count_r <= 1'b0;
      null_r <= 1'b1;
    end else begin
      if (tick) begin
        case (mode_r)
          MODE_TERM, MODE_STROBE: begin
            if (load_pend_r) begin
              count_element_r <= count_holding_register_r;
              load_pend_r <= 1'b0;
              run_r <= 1'b1;
              null_r <= 1'b0;
              out_r <= (mode_r == MODE_STROBE) ? 1'b1 : 1'b0;
            end else if (gate_s && !(lsb_wait_r && mode_r == MODE_TERM)) begin
              count_element_r <= dec_one;
              if (run_r && dec_one == 16'h0000) begin
                out_r <= (mode_r == MODE_TERM);
                run_r <= 1'b0;
              end else if (mode_r == MODE_STROBE) begin
                out_r <= 1'b1;
              end
            end else if (mode_r == MODE_STROBE) begin
              out_r <= 1'b1;
            end
          end
          MODE_ONESHOT: begin
            if (trig_pend_r && have_count_r) begin
              count_element_r <= count_holding_register_r;
              out_r <= 1'b0;
              run_r <= 1'b1;
              null_r <= 1'b0;
            end else begin
              count_element_r <= dec_one;
              if (run_r && dec_one == 16'h0000) begin
                out_r <= 1'b1;
                run_r <= 1'b0;
              end
            end
          end
          MODE_RATE: begin
            if (((trig_pend_r && gate_s) || load_pend_r) && have_count_r) begin
              count_element_r <= count_holding_register_r;
              out_r <= 1'b1;
              load_pend_r <= 1'b0;
              run_r <= 1'b1;
              null_r <= 1'b0;
            end else if (gate_s && run_r) begin
              if (count_element_r == `ICT_RATE_TERM) begin
                count_element_r <= count_holding_register_r;
                out_r <= 1'b1;
                null_r <= 1'b0;
              end else begin
                count_element_r <= dec_one;
                out_r <= (dec_one != `ICT_RATE_TERM);
              end
            end
          end
          MODE_SQUARE: begin
            if (((trig_pend_r && gate_s) || load_pend_r) && have_count_r) begin
              count_element_r <= sq_reload;
              out_r <= 1'b1;
              load_pend_r <= 1'b0;
              run_r <= 1'b1;
              null_r <= 1'b0;
            end else if (gate_s && run_r) begin
              if (sq_term) begin
                count_element_r <= sq_reload;
                out_r <= ~out_r;
                null_r <= 1'b0;
              end else begin
                count_element_r <= dec_two;
              end
            end
          end
          default: begin
            count_element_r <= count_element_r;
          end
        endcase
      end
      // Gate low ends a low phase at once, without waiting for a clock
      if ((mode_r == MODE_RATE || mode_r == MODE_SQUARE) && !gate_s && !out_r) begin
        out_r <= 1'b1;
      end
      if (first_byte && mode_r == MODE_TERM) begin
        out_r <= 1'b0;
        run_r <= 1'b0;
        load_pend_r <= 1'b0;
      end
      // Count writes land last so a same-cycle load never loses them
      if (count_done) begin
        have_count_r <= 1'b1;
        null_r <= 1'b1;
        if (mode_r == MODE_TERM) begin
          out_r <= 1'b0;
        end
        if (mode_r == MODE_TERM || mode_r == MODE_STROBE) begin
          load_pend_r <= 1'b1;
        end else if ((mode_r == MODE_RATE || mode_r == MODE_SQUARE) && !have_count_r) begin
          load_pend_r <= 1'b1;
        end
      end
    end
  end

  // Read data prepared in the setup cycle, answered in the first access cycle
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    if (PADDR == `ICT_OFS_CTRL) begin
      prdata_nxt = {26'h000_0000, cw_r};
    end else if (PADDR == `ICT_OFS_COUNT) begin
      prdata_nxt = {16'h0000, count_holding_register_r};
    end else if (PADDR == `ICT_OFS_STATUS) begin
      prdata_nxt = {24'h00_0000, out_r, null_r, cw_r};
    end else if (PADDR == `ICT_OFS_ELEMENT) begin
      prdata_nxt = {16'h0000, count_element_r};
    end else begin
      pslverr_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup & pslverr_nxt;
      if (setup && !PWRITE) begin
        prdata_r <= prdata_nxt;
      end
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign OUT = out_r;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  chk_term_ctrl_low: assert property (ctrl_wr && new_mode == MODE_TERM |=> !OUT)
    else $error("mode 0 output not low after control word");

  chk_term_gate_hold: assert property (
    tick && mode_r == MODE_TERM && !gate_s && !load_pend_r && !ctrl_wr |=> $stable(count_element_r))
    else $error("mode 0 count moved with gate low");

  chk_term_load_plain: assert property (
    tick && mode_r == MODE_TERM && load_pend_r && !ctrl_wr
    |=> count_element_r == $past(count_holding_register_r))
    else $error("mode 0 load decremented or missed");

  chk_term_first_byte: assert property (
    first_byte && mode_r == MODE_TERM && !ctrl_wr |=> !OUT && !run_r)
    else $error("mode 0 first byte did not suspend");

  chk_oneshot_trigger: assert property (
    tick && mode_r == MODE_ONESHOT && trig_pend_r && have_count_r && !ctrl_wr && !count_done |=> !OUT)
    else $error("mode 1 trigger did not drive output low");

  chk_rate_reload: assert property (
    tick && mode_r == MODE_RATE && gate_s && run_r && !trig_pend_r && !load_pend_r && !ctrl_wr
    && count_element_r == `ICT_RATE_TERM
    |=> OUT && count_element_r == $past(count_holding_register_r))
    else $error("mode 2 did not reload at one");

  chk_gate_forces_high: assert property (
    (mode_r == MODE_RATE || mode_r == MODE_SQUARE) && !gate_s && !OUT && !ctrl_wr |=> OUT)
    else $error("gate low did not force output high");

  chk_square_step: assert property (
    tick && mode_r == MODE_SQUARE && gate_s && run_r && !sq_term && !trig_pend_r && !load_pend_r
    && !ctrl_wr && !cw_r[`ICT_CW_BCD] |=> count_element_r == $past(count_element_r) - 16'h0002)
    else $error("mode 3 did not step by two");

  chk_strobe_one_clock: assert property (
    mode_r == MODE_STROBE && !OUT && tick && !ctrl_wr && !count_done |=> OUT)
    else $error("mode 4 strobe longer than one clock");
endmodule : ict_counter

//--- test/ict_host.sv
// Host processor model: APB master that writes control words and counts
`timescale 1ns/1ns
module ict_host (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // One transfer; ok stays low if the slave never answers
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic err, output logic ok);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    ok = 1'b0;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge clk);
      ok = pready;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data must not keep showing the old word
    pwdata <= ~d;
  endtask : xfer
endmodule : ict_host

//--- test/test_interval_counter_modes_zero_to_four.sv
// Self-checking bench for one interval counter channel in modes 0 to 4
`timescale 1ns/1ns
`include "ict_map.svh"
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin n_fail++; $display("[ERR] %0t %s", $time, msg); end end
module test_interval_counter_modes_zero_to_four;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, out;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic cnt_clk = 1'b0;
  logic gate = 1'b0;
  int n_fail = 0;
  int comparisons = 0;

  always #4 clk_sys = ~clk_sys;

  ict_counter dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CNT_CLK(cnt_clk), .GATE(gate), .OUT(out));

  ict_host host (.clk(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    logic ok;
    host.xfer(1'b0, a, 32'h0000_0000, q, e, ok);
    if (!ok) begin
      n_fail++;
      summarize();
    end
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e, ok;
    host.xfer(1'b1, a, d, q, e, ok);
    if (!ok) begin
      n_fail++;
      summarize();
    end else begin
      repeat (4) @(posedge clk_sys);
    end
  endtask : wr

  // Counter clock only moves here; 8 system cycles per phase leaves OUT settled
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk_sys) cnt_clk <= 1'b1;
      repeat (8) @(posedge clk_sys);
      cnt_clk <= 1'b0;
      repeat (8) @(posedge clk_sys);
    end
  endtask : tick

  task automatic t_mode1;
    wr(`ICT_OFS_CTRL, 32'h0000_0012);
    `CHK(out, 1'b1, "mode 1 idle level")
    wr(`ICT_OFS_COUNT, 32'h0000_0002);
    tick(2);
    `CHK(out, 1'b1, "mode 1 started without trigger")
    gate <= 1'b1;
    tick(1);
    `CHK(out, 1'b0, "mode 1 trigger ignored")
    gate <= 1'b0;
    tick(1);
    `CHK(out, 1'b0, "mode 1 gate fall changed output")
    gate <= 1'b1;
    tick(1);
    `CHK(out, 1'b0, "mode 1 retrigger")
    wr(`ICT_OFS_COUNT, 32'h0000_0005);
    tick(1);
    `CHK(out, 1'b0, "mode 1 pulse too short")
    tick(1);
    `CHK(out, 1'b1, "mode 1 new count disturbed pulse")
    tick(2);
    `CHK(out, 1'b1, "mode 1 pulse repeated")
  endtask : t_mode1

  task automatic t_mode0;
    wr(`ICT_OFS_CTRL, 32'h0000_0010);
    `CHK(out, 1'b0, "mode 0 control word level")
    wr(`ICT_OFS_COUNT, 32'h0000_0003);
    for (int i = 0; i < 3; i++) begin
      tick(1);
      `CHK(out, 1'b0, "mode 0 early rise")
    end
    tick(1);
    `CHK(out, 1'b1, "mode 0 terminal count")
    gate <= 1'b0;
    wr(`ICT_OFS_COUNT, 32'h0000_0003);
    tick(4);
    `CHK(out, 1'b0, "mode 0 counted with gate low")
    gate <= 1'b1;
    tick(2);
    `CHK(out, 1'b0, "mode 0 early after gate")
    tick(1);
    `CHK(out, 1'b1, "mode 0 late after gate")
  endtask : t_mode0

  task automatic t_mode0_split;
    logic [31:0] q;
    logic e;
    wr(`ICT_OFS_CTRL, 32'h0000_0030);
    wr(`ICT_OFS_COUNT, 32'h0000_0002);
    wr(`ICT_OFS_COUNT, 32'h0000_0000);
    tick(3);
    `CHK(out, 1'b1, "mode 0 two-byte count")
    wr(`ICT_OFS_COUNT, 32'h0000_0001);
    `CHK(out, 1'b0, "mode 0 first byte kept output")
    tick(2);
    `CHK(out, 1'b0, "mode 0 counted between bytes")
    rd(`ICT_OFS_ELEMENT, q, e);
    `CHK(q[15:0], 16'h0000, "mode 0 element moved between bytes")
    wr(`ICT_OFS_COUNT, 32'h0000_0000);
    tick(1);
    `CHK(out, 1'b0, "mode 0 second byte early")
    tick(1);
    `CHK(out, 1'b1, "mode 0 second byte late")
  endtask : t_mode0_split

  task automatic t_mode2;
    wr(`ICT_OFS_CTRL, 32'h0000_0014);
    `CHK(out, 1'b1, "mode 2 idle level")
    wr(`ICT_OFS_COUNT, 32'h0000_0003);
    for (int i = 1; i <= 6; i++) begin
      tick(1);
      `CHK(out, logic'(i % 3 != 0), "mode 2 rate pattern")
    end
    gate <= 1'b0;
    repeat (6) @(posedge clk_sys);
    `CHK(out, 1'b1, "mode 2 gate fall not forcing high")
    tick(2);
    `CHK(out, 1'b1, "mode 2 counted with gate low")
    gate <= 1'b1;
    tick(2);
    `CHK(out, 1'b1, "mode 2 restart early")
    tick(1);
    `CHK(out, 1'b0, "mode 2 restart late")
  endtask : t_mode2

  // Phase-free: level repeats every n ticks, low for n/2 of them
  task automatic t_mode3(input int n);
    logic s [0:19];
    int lows;
    lows = 0;
    wr(`ICT_OFS_CTRL, 32'h0000_0016);
    `CHK(out, 1'b1, "mode 3 idle level")
    wr(`ICT_OFS_COUNT, n);
    tick(2);
    for (int k = 0; k < 2 * n; k++) begin
      tick(1);
      s[k] = out;
      lows += (out === 1'b0);
      if (k >= n) `CHK(s[k], s[k - n], "mode 3 period")
    end
    `CHK(lows, 2 * (n / 2), "mode 3 duty")
  endtask : t_mode3

  task automatic t_mode4;
    wr(`ICT_OFS_CTRL, 32'h0000_0018);
    `CHK(out, 1'b1, "mode 4 idle level")
    wr(`ICT_OFS_COUNT, 32'h0000_0003);
    tick(3);
    `CHK(out, 1'b1, "mode 4 early strobe")
    tick(1);
    `CHK(out, 1'b0, "mode 4 strobe missing")
    tick(1);
    `CHK(out, 1'b1, "mode 4 strobe width")
    gate <= 1'b0;
    wr(`ICT_OFS_COUNT, 32'h0000_0002);
    tick(5);
    `CHK(out, 1'b1, "mode 4 counted with gate low")
    gate <= 1'b1;
    tick(2);
    `CHK(out, 1'b0, "mode 4 strobe after gate")
  endtask : t_mode4

  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd(`ICT_OFS_CTRL, q, e);
    `CHK(q[5:0], 6'h18, "control readback")
    rd(8'h10, q, e);
    `CHK(e, 1'b1, "unmapped address accepted")
    `CHK(q, 32'h0000_0000, "unmapped read data")
  endtask : t_regs

  // BCD count of ten: element steps to 09, output rises on the eleventh pulse
  task automatic t_bcd;
    logic [31:0] q;
    logic e;
    wr(`ICT_OFS_CTRL, 32'h0000_0011);
    wr(`ICT_OFS_COUNT, 32'h0000_0010);
    tick(2);
    rd(`ICT_OFS_ELEMENT, q, e);
    `CHK(q[15:0], 16'h0009, "BCD step from ten")
    tick(8);
    `CHK(out, 1'b0, "BCD count ended early")
    tick(1);
    `CHK(out, 1'b1, "BCD count ended late")
  endtask : t_bcd

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    `CHK(out, 1'b0, "output after reset")
    t_mode1();
    t_mode0();
    t_mode0_split();
    t_mode2();
    gate <= 1'b1;
    t_mode3(4);
    t_mode3(5);
    t_mode4();
    t_regs();
    t_bcd();
    summarize();
  end
endmodule : test_interval_counter_modes_zero_to_four
